// ===== shared/ecs_pkg.sv
/*
 * ecs_pkg: constants, types and the state record of the EEPROM command sequencer.
 * Assumes a single 50 MHz core clock and a plain one-cycle register port.
 */
package ecs_pkg;

	// ----------------------------------------------------------------
	// clock and step timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int STEP_TIME_NS = 1000;
	localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] STEP_LAST = 6'(STEP_CYCLES - 1);

	// ----------------------------------------------------------------
	// register offsets (word index on the register port)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_ERCFG = 4'h1;
	localparam logic [3:0] REG_STAT = 4'h2;
	localparam logic [3:0] REG_ERSTAT = 4'h3;
	localparam logic [3:0] REG_IDX = 4'h4;
	localparam logic [3:0] REG_PARAM = 4'h5;
	localparam logic [3:0] REG_PROT = 4'h6;
	localparam logic [3:0] REG_EEDATA = 4'h7;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int DONE_IE_BIT = 7;
	localparam int DBL_IE_BIT = 1;
	localparam int SGL_IE_BIT = 0;
	localparam int DONE_BIT = 7;
	localparam int ACC_ERR_BIT = 5;
	localparam int PROT_VIOL_BIT = 4;
	localparam int MGS1_BIT = 1;
	localparam int MGS0_BIT = 0;
	localparam int DBL_FLAG_BIT = 1;
	localparam int SGL_FLAG_BIT = 0;
	localparam int PROT_EN_BIT = 7;

	// ----------------------------------------------------------------
	// command codes and memory geometry
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
	localparam logic [7:0] CMD_PROGRAM = 8'h11;
	localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
	localparam logic [2:0] IDX_ERASE_VERIFY = 3'h2;
	localparam logic [2:0] IDX_PGM_MIN = 3'h2;
	localparam logic [2:0] IDX_PGM_MAX = 3'h5;
	localparam logic [2:0] IDX_ERASE_SECTOR = 3'h1;
	localparam logic [17:0] EE_BASE = 18'h00400;
	localparam logic [17:0] EE_LAST = 18'h0047F;
	localparam logic [16:0] EE_WORDS = 17'h00040;
	localparam logic [15:0] ERASED_WORD = 16'hFFFF;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic DONE_RST = 1'b1;
	localparam logic [63:0][15:0] MEM_RST = {64{16'hFFFF}};

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_CHECK} ecs_fsm_t;
	typedef enum logic [1:0] {OP_EVS, OP_PGM, OP_ERS} ecs_op_t;

	typedef struct packed {
		logic wr; // write strobe
		logic rd; // read strobe
		logic [3:0] addr; // register index
		logic [15:0] wdata; // write data
	} ecs_bus_req_t;

	typedef struct packed {
		logic done_ie;
		logic dbl_ie;
		logic sgl_ie;
		logic done_flag;
		logic access_err;
		logic prot_viol;
		logic mgs1;
		logic mgs0;
		logic dbl_flag;
		logic sgl_flag;
		logic [2:0] idx;
		logic [5:0][15:0] slot;
		logic prot_en;
		logic [5:0] prot_start;
		ecs_fsm_t fsm;
		ecs_op_t op;
		logic [5:0] cur;
		logic [5:0] first;
		logic [5:0] last;
		logic [5:0] div;
		logic [63:0][15:0] mem;
		logic [15:0] rdata;
		logic cmd_irq;
		logic err_irq;
	} ecs_state_t;

	localparam ecs_state_t STATE_RST = '{
		done_flag: DONE_RST,
		fsm: ST_IDLE,
		op: OP_EVS,
		mem: MEM_RST,
		default: '0
	};

endpackage : ecs_pkg

// ===== core/ecs_top.sv
/*
 * ecs_top: EEPROM command sequencer with erase-verify-section, program and
 * erase-sector commands, verify status, and command/ECC interrupt requests.
 * Assumes inputs synchronous to core_clk and ECC fault strobes from the read path.
 */
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module ecs_top (
	input wire logic core_clk, // 50 MHz system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire ecs_pkg::ecs_bus_req_t bus_req, // register port request
	output logic [15:0] rd_data, // read data, cycle after read strobe
	input wire logic cmd_permit, // command allowed in mode and security state
	input wire logic ecc_sbit_fault, // correctable fault on current verify read
	input wire logic ecc_dbit_fault, // uncorrectable fault on current verify read
	output logic cmd_irq, // command complete interrupt request
	output logic err_irq // ECC fault interrupt request
);

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// word index of a global address inside the EEPROM
	function automatic logic [5:0] ee_word(input logic [17:0] gaddr);
		logic [17:0] off;
		off = gaddr - ecs_pkg::EE_BASE;
		return off[6:1];
	endfunction : ee_word

	// parameter slot feeding the current program word
	function automatic logic [2:0] pgm_slot(input logic [5:0] cur, input logic [5:0] first);
		logic [5:0] d;
		d = cur - first;
		return 3'(d[1:0]) + 3'h2;
	endfunction : pgm_slot

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic srst_n;

	// two-stage reset release
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_q <= 2'h0;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign srst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// state and launch decode
	// ----------------------------------------------------------------
	ecs_pkg::ecs_state_t s_q;
	ecs_pkg::ecs_state_t s_d;
	logic [7:0] code;
	logic [17:0] gaddr;
	logic [5:0] word0;
	logic addr_ok;
	logic code_ok;
	logic idx_ok;
	logic breach;
	logic [16:0] evs_end;
	logic [6:0] pgm_last;
	logic [5:0] sec_first;
	logic [5:0] op_last;
	logic prot_hit;
	logic acc_err;
	logic launch_w;
	logic [15:0] cur_word;
	logic [15:0] exp_word;
	logic mismatch;
	logic tick;
	ecs_pkg::ecs_op_t op_sel;

	// command fields from the parameter slots
	assign code = s_q.slot[0][15:8];
	// block bits join the low address
	assign gaddr = {s_q.slot[0][1:0], s_q.slot[1]};
	assign word0 = ee_word(gaddr);
	// address must lie in the EEPROM
	assign addr_ok = (gaddr >= ecs_pkg::EE_BASE) && (gaddr <= ecs_pkg::EE_LAST);
	assign code_ok = (code == ecs_pkg::CMD_ERASE_VERIFY) || (code == ecs_pkg::CMD_PROGRAM)
		|| (code == ecs_pkg::CMD_ERASE_SECTOR);
	assign evs_end = {11'h000, word0} + {1'b0, s_q.slot[2]};
	assign pgm_last = {1'b0, word0} + 7'(s_q.idx) - 7'h2;
	assign sec_first = {word0[5:1], 1'b0};

	// per-command index check, range check for erase-verify and program, and last word
	always_comb
	begin
		op_sel = ecs_pkg::OP_EVS;
		idx_ok = 1'b0;
		breach = 1'b0;
		op_last = word0;
		case (code)
			ecs_pkg::CMD_ERASE_VERIFY:
			begin
				idx_ok = (s_q.idx == ecs_pkg::IDX_ERASE_VERIFY);
				breach = (s_q.slot[2] == 16'h0000) || (evs_end > ecs_pkg::EE_WORDS);
				op_last = 6'(evs_end - 17'h1);
			end
			ecs_pkg::CMD_PROGRAM:
			begin
				op_sel = ecs_pkg::OP_PGM;
				idx_ok = (s_q.idx >= ecs_pkg::IDX_PGM_MIN) && (s_q.idx <= ecs_pkg::IDX_PGM_MAX);
				breach = pgm_last[6];
				op_last = pgm_last[5:0];
			end
			ecs_pkg::CMD_ERASE_SECTOR:
			begin
				op_sel = ecs_pkg::OP_ERS;
				idx_ok = (s_q.idx == ecs_pkg::IDX_ERASE_SECTOR);
				op_last = sec_first | 6'h01;
			end
			default:
			begin
				idx_ok = 1'b0;
			end
		endcase
	end

	assign prot_hit = s_q.prot_en && (op_last >= s_q.prot_start);
	// permission, alignment and the other launch checks
	assign acc_err = !cmd_permit || !code_ok || !addr_ok || gaddr[0] || !idx_ok || breach;
	// launch only while idle and no error pending
	assign launch_w = bus_req.wr && (bus_req.addr == ecs_pkg::REG_STAT)
		&& bus_req.wdata[ecs_pkg::DONE_BIT] && s_q.done_flag && !s_q.access_err && !s_q.prot_viol;

	// step pacing and verify compare
	assign tick = (s_q.fsm != ecs_pkg::ST_IDLE) && (s_q.div == ecs_pkg::STEP_LAST);
	assign cur_word = s_q.mem[s_q.cur];
	assign exp_word = (s_q.op == ecs_pkg::OP_PGM) ? s_q.slot[pgm_slot(s_q.cur, s_q.first)]
		: ecs_pkg::ERASED_WORD;
	assign mismatch = (cur_word != exp_word);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rdata = 16'h0000;
		// step divider runs only while busy
		if (s_q.fsm == ecs_pkg::ST_IDLE || tick)
			s_d.div = 6'h00;
		else
			s_d.div = s_q.div + 6'h01;

		// register writes
		if (bus_req.wr)
		begin
			case (bus_req.addr)
				ecs_pkg::REG_CFG:
					s_d.done_ie = bus_req.wdata[ecs_pkg::DONE_IE_BIT];
				ecs_pkg::REG_ERCFG:
				begin
					s_d.dbl_ie = bus_req.wdata[ecs_pkg::DBL_IE_BIT];
					s_d.sgl_ie = bus_req.wdata[ecs_pkg::SGL_IE_BIT];
				end
				ecs_pkg::REG_STAT:
				begin
					if (bus_req.wdata[ecs_pkg::ACC_ERR_BIT])
						s_d.access_err = 1'b0;
					if (bus_req.wdata[ecs_pkg::PROT_VIOL_BIT])
						s_d.prot_viol = 1'b0;
				end
				ecs_pkg::REG_ERSTAT:
				begin
					if (bus_req.wdata[ecs_pkg::DBL_FLAG_BIT])
						s_d.dbl_flag = 1'b0;
					if (bus_req.wdata[ecs_pkg::SGL_FLAG_BIT])
						s_d.sgl_flag = 1'b0;
				end
				ecs_pkg::REG_IDX:
				begin
					if (s_q.done_flag)
						s_d.idx = bus_req.wdata[2:0];
				end
				ecs_pkg::REG_PARAM:
				begin
					if (s_q.done_flag && s_q.idx <= 3'h5)
						s_d.slot[s_q.idx] = bus_req.wdata;
				end
				ecs_pkg::REG_PROT:
				begin
					if (s_q.done_flag)
					begin
						s_d.prot_en = bus_req.wdata[ecs_pkg::PROT_EN_BIT];
						s_d.prot_start = bus_req.wdata[5:0];
					end
				end
				default:
				begin
					s_d.rdata = 16'h0000;
				end
			endcase
		end

		// register reads, unmapped reads return zero
		if (bus_req.rd)
		begin
			case (bus_req.addr)
				ecs_pkg::REG_CFG:
					s_d.rdata[ecs_pkg::DONE_IE_BIT] = s_q.done_ie;
				ecs_pkg::REG_ERCFG:
					s_d.rdata = {14'h0000, s_q.dbl_ie, s_q.sgl_ie};
				ecs_pkg::REG_STAT:
					s_d.rdata = {8'h00, s_q.done_flag, 1'b0, s_q.access_err, s_q.prot_viol,
						2'h0, s_q.mgs1, s_q.mgs0};
				ecs_pkg::REG_ERSTAT:
					s_d.rdata = {14'h0000, s_q.dbl_flag, s_q.sgl_flag};
				ecs_pkg::REG_IDX:
					s_d.rdata = {13'h0000, s_q.idx};
				ecs_pkg::REG_PARAM:
					s_d.rdata = (s_q.idx <= 3'h5) ? s_q.slot[s_q.idx] : 16'h0000;
				ecs_pkg::REG_PROT:
					s_d.rdata = {8'h00, s_q.prot_en, 1'b0, s_q.prot_start};
				ecs_pkg::REG_EEDATA:
					s_d.rdata = addr_ok ? s_q.mem[word0] : 16'h0000;
				default:
					s_d.rdata = 16'h0000;
			endcase
		end

		// launch on clearing the complete flag
		if (launch_w)
		begin
			s_d.mgs1 = 1'b0;
			s_d.mgs0 = 1'b0;
			if (acc_err)
				s_d.access_err = 1'b1;
			else if (prot_hit && op_sel != ecs_pkg::OP_EVS)
				s_d.prot_viol = 1'b1;
			else
			begin
				// word count via last word: program from index, erase-verify from slot 2
				s_d.done_flag = 1'b0;
				s_d.op = op_sel;
				s_d.first = (op_sel == ecs_pkg::OP_ERS) ? sec_first : word0;
				s_d.cur = (op_sel == ecs_pkg::OP_ERS) ? sec_first : word0;
				s_d.last = op_last;
				s_d.div = 6'h00;
				s_d.fsm = (op_sel == ecs_pkg::OP_EVS) ? ecs_pkg::ST_CHECK : ecs_pkg::ST_WRITE;
			end
		end

		// sequencer
		case (s_q.fsm)
			ecs_pkg::ST_IDLE:
			begin
				s_d.cur = s_d.cur;
			end
			ecs_pkg::ST_WRITE:
			begin
				if (tick)
				begin
					// program data from slots 2..5, erase to blank
					if (s_q.op == ecs_pkg::OP_PGM)
						s_d.mem[s_q.cur] = s_q.slot[pgm_slot(s_q.cur, s_q.first)];
					else
						s_d.mem[s_q.cur] = ecs_pkg::ERASED_WORD;
					if (s_q.cur == s_q.last)
					begin
						s_d.cur = s_q.first;
						s_d.fsm = ecs_pkg::ST_CHECK;
					end
					else
						s_d.cur = s_q.cur + 6'h01;
				end
			end
			ecs_pkg::ST_CHECK:
			begin
				if (tick)
				begin
					if (mismatch || ecc_dbit_fault || ecc_sbit_fault)
						s_d.mgs1 = 1'b1;
					if (mismatch || ecc_dbit_fault)
						s_d.mgs0 = 1'b1;
					// fault flags, set wins over clear
					if (ecc_dbit_fault)
						s_d.dbl_flag = 1'b1;
					if (ecc_sbit_fault)
						s_d.sgl_flag = 1'b1;
					if (s_q.cur == s_q.last)
					begin
						s_d.fsm = ecs_pkg::ST_IDLE;
						s_d.done_flag = 1'b1;
					end
					else
						s_d.cur = s_q.cur + 6'h01;
				end
			end
			default:
			begin
				s_d.fsm = ecs_pkg::ST_IDLE;
				s_d.done_flag = 1'b1;
			end
		endcase

		s_d.cmd_irq = s_d.done_flag && s_d.done_ie;
		s_d.err_irq = (s_d.dbl_flag && s_d.dbl_ie) || (s_d.sgl_flag && s_d.sgl_ie);
	end

	// state register
	always_ff @(posedge core_clk or negedge srst_n)
	begin
		if (!srst_n)
			s_q <= ecs_pkg::STATE_RST;
		else
			s_q <= s_d;
	end

	// outputs straight from the state register
	assign rd_data = s_q.rdata;
	assign cmd_irq = s_q.cmd_irq;
	assign err_irq = s_q.err_irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!srst_n);

	a_evs_idx_error: assert property (
		launch_w && code == ecs_pkg::CMD_ERASE_VERIFY && s_q.idx != 3'h2
		|=> s_q.access_err && s_q.done_flag && s_q.fsm == ecs_pkg::ST_IDLE)
		else $error("erase-verify with bad index not refused");

	a_permit_error: assert property (
		launch_w && !cmd_permit |=> s_q.access_err && s_q.done_flag)
		else $error("unpermitted command not refused");

	a_misalign_error: assert property (
		launch_w && gaddr[0] |=> s_q.access_err ##1 s_q.done_flag)
		else $error("misaligned address not refused");

	a_pgm_idx_error: assert property (
		launch_w && code == ecs_pkg::CMD_PROGRAM && (s_q.idx < 3'h2 || s_q.idx > 3'h5)
		|=> s_q.access_err)
		else $error("program with bad index not refused");

	a_ers_idx_error: assert property (
		launch_w && code == ecs_pkg::CMD_ERASE_SECTOR && s_q.idx != 3'h1
		|=> s_q.access_err && $stable(s_q.mem))
		else $error("erase-sector with bad index not refused");

	a_evs_no_protection_violation_flag: assert property (
		s_q.op == ecs_pkg::OP_EVS && s_q.fsm != ecs_pkg::ST_IDLE |-> !s_q.prot_viol)
		else $error("protection flag during erase-verify");

	a_irq_follows: assert property (
		s_q.done_flag && s_q.done_ie && !s_q.dbl_flag && !s_q.sgl_flag |-> cmd_irq && !err_irq)
		else $error("interrupt requests disagree with flags");

	a_busy_frozen: assert property (
		s_q.fsm != ecs_pkg::ST_IDLE && !tick && bus_req.wr && bus_req.addr == ecs_pkg::REG_IDX
		|=> !s_q.done_flag && $stable(s_q.idx))
		else $error("index changed while busy");

	c_evs_done: cover property (
		s_q.op == ecs_pkg::OP_EVS && $rose(s_q.done_flag));
	c_pgm_done: cover property (
		s_q.op == ecs_pkg::OP_PGM && $rose(s_q.done_flag) && !s_q.mgs1);
	c_ers_done: cover property (
		s_q.op == ecs_pkg::OP_ERS && $rose(s_q.done_flag));
	c_prot_hit: cover property ($rose(s_q.prot_viol));

endmodule : ecs_top

// ===== verification/ecs_top_test.sv
/*
 * ecs_top_test: self-checking bench for the EEPROM command sequencer.
 * Assumes the register map and step timing of ecs_pkg; the bench drives every input port itself.
 */
`timescale 1ns/1ns
module ecs_top_test;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic core_clk = 1'b0; // bench clock
	logic rst_n = 1'b0; // reset, active low
	ecs_pkg::ecs_bus_req_t bus_req = '0; // register port request
	logic [15:0] rd_data; // register read data
	logic cmd_permit = 1'b1; // mode and security permit
	logic ecc_sbit_fault = 1'b0; // correctable read fault
	logic ecc_dbit_fault = 1'b0; // uncorrectable read fault
	logic cmd_irq; // command complete request
	logic err_irq; // fault request
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [15:0] pw [2:5]; // values for slots 2 to 5
	// refused launches: code, global address, final index
	localparam logic [28:0] ERR_CASES [10] = '{
		{8'h10, 18'h00400, 3'h1}, {8'h10, 18'h10400, 3'h2}, {8'h10, 18'h00401, 3'h2},
		{8'h10, 18'h0047E, 3'h2}, {8'h11, 18'h00400, 3'h1}, {8'h11, 18'h00400, 3'h6},
		{8'h11, 18'h0047C, 3'h5}, {8'h12, 18'h00400, 3'h2}, {8'h12, 18'h00480, 3'h1},
		{8'h11, 18'h003FE, 3'h2}};

	always #(ecs_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

	ecs_top u_dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.cmd_permit(cmd_permit),
		.ecc_sbit_fault(ecc_sbit_fault),
		.ecc_dbit_fault(ecc_dbit_fault),
		.cmd_irq(cmd_irq),
		.err_irq(err_irq)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("FAIL at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one-cycle write strobe, then idle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		bus_req <= '0;
	endtask : wr

	// data is taken in the cycle after the read strobe
	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge core_clk);
		bus_req <= '0;
		@(negedge core_clk);
		chk(rd_data, exp);
	endtask : rdchk

	task automatic setp(input logic [2:0] i, input logic [15:0] d);
		wr(ecs_pkg::REG_IDX, {13'h0000, i});
		wr(ecs_pkg::REG_PARAM, d);
	endtask : setp

	// load slots, leave the index at last, launch
	task automatic issue(input logic [7:0] code, input logic [17:0] a, input logic [2:0] last);
		setp(3'h0, {code, 6'h00, a[17:16]});
		setp(3'h1, a[15:0]);
		for (int i = 2; i <= 5 && i <= last; i++)
			setp(3'(i), pw[i]);
		wr(ecs_pkg::REG_IDX, {13'h0000, last});
		wr(ecs_pkg::REG_STAT, 16'h0080);
	endtask : issue

	// poll until complete, compare status, clear error flags
	task automatic fin(input logic [15:0] exp);
		logic [15:0] d;
		d = 16'h0000;
		for (int k = 0; k < 1000 && d[7] !== 1'b1; k++)
		begin
			@(posedge core_clk);
			bus_req <= '{wr: 1'b0, rd: 1'b1, addr: ecs_pkg::REG_STAT, wdata: 16'h0000};
			@(posedge core_clk);
			bus_req <= '0;
			@(negedge core_clk);
			d = rd_data;
		end
		chk(d, exp);
		wr(ecs_pkg::REG_STAT, 16'h0030);
	endtask : fin

	task automatic wchk(input logic [15:0] a, input logic [15:0] exp);
		setp(3'h0, 16'h0000);
		setp(3'h1, a);
		rdchk(ecs_pkg::REG_EEDATA, exp);
	endtask : wchk

	// cycle ceiling against a hang
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			fails++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rdchk(ecs_pkg::REG_STAT, 16'h0080);
		chk({15'h0000, cmd_irq}, 16'h0000);
		pw = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
		issue(ecs_pkg::CMD_PROGRAM, 18'h00400, 3'h5);
		fin(16'h0080);
		for (int i = 0; i < 4; i++)
			wchk(16'(16'h0400 + 2 * i), pw[i + 2]);
		wchk(16'h0408, 16'hFFFF);
		// program only a word seen erased
		issue(ecs_pkg::CMD_PROGRAM, 18'h00408, 3'h2);
		fin(16'h0080);
		wchk(16'h0408, 16'h1234);
		wchk(16'h040A, 16'hFFFF);
		$display("test program done");
		pw[2] = 16'h0004;
		issue(ecs_pkg::CMD_ERASE_VERIFY, 18'h00400, 3'h2);
		fin(16'h0083);
		pw[2] = 16'h0010;
		issue(ecs_pkg::CMD_ERASE_VERIFY, 18'h00460, 3'h2);
		fin(16'h0080);
		$display("test erase verify done");
		issue(ecs_pkg::CMD_ERASE_SECTOR, 18'h00402, 3'h1);
		fin(16'h0080);
		wchk(16'h0400, 16'hFFFF);
		wchk(16'h0402, 16'hFFFF);
		wchk(16'h0404, 16'h9ABC);
		$display("test erase sector done");
		pw[2] = 16'h0002;
		foreach (ERR_CASES[n])
		begin
			issue(ERR_CASES[n][28:21], ERR_CASES[n][20:3], ERR_CASES[n][2:0]);
			fin(16'h00A0);
		end
		cmd_permit <= 1'b0;
		issue(ecs_pkg::CMD_ERASE_VERIFY, 18'h00400, 3'h2);
		fin(16'h00A0);
		cmd_permit <= 1'b1;
		$display("test access errors done");
		wr(ecs_pkg::REG_PROT, 16'h00A0);
		issue(ecs_pkg::CMD_PROGRAM, 18'h0043E, 3'h3);
		fin(16'h0090);
		wchk(16'h043E, 16'hFFFF);
		issue(ecs_pkg::CMD_ERASE_SECTOR, 18'h00442, 3'h1);
		fin(16'h0090);
		issue(ecs_pkg::CMD_ERASE_VERIFY, 18'h00440, 3'h2);
		fin(16'h0080);
		issue(ecs_pkg::CMD_PROGRAM, 18'h0043C, 3'h3);
		fin(16'h0080);
		wchk(16'h043E, 16'h5678);
		wr(ecs_pkg::REG_PROT, 16'h0000);
		$display("test protection done");
		wr(ecs_pkg::REG_CFG, 16'h0080);
		repeat (2) @(posedge core_clk);
		chk({15'h0000, cmd_irq}, 16'h0001);
		issue(ecs_pkg::CMD_PROGRAM, 18'h00410, 3'h2);
		rdchk(ecs_pkg::REG_STAT, 16'h0000);
		chk({15'h0000, cmd_irq}, 16'h0000);
		wr(ecs_pkg::REG_PARAM, 16'h0BAD);
		wr(ecs_pkg::REG_IDX, 16'h0003);
		wr(ecs_pkg::REG_STAT, 16'h0080);
		fin(16'h0080);
		rdchk(ecs_pkg::REG_IDX, 16'h0002);
		rdchk(ecs_pkg::REG_PARAM, 16'h0002);
		chk({15'h0000, cmd_irq}, 16'h0001);
		$display("test busy done");
		wr(ecs_pkg::REG_ERCFG, 16'h0003);
		ecc_sbit_fault <= 1'b1;
		issue(ecs_pkg::CMD_ERASE_VERIFY, 18'h00400, 3'h2);
		fin(16'h0082);
		ecc_sbit_fault <= 1'b0;
		rdchk(ecs_pkg::REG_ERSTAT, 16'h0001);
		chk({15'h0000, err_irq}, 16'h0001);
		wr(ecs_pkg::REG_ERSTAT, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk({15'h0000, err_irq}, 16'h0000);
		wr(ecs_pkg::REG_ERCFG, 16'h0001);
		ecc_dbit_fault <= 1'b1;
		issue(ecs_pkg::CMD_PROGRAM, 18'h00420, 3'h2);
		fin(16'h0083);
		ecc_dbit_fault <= 1'b0;
		rdchk(ecs_pkg::REG_ERSTAT, 16'h0002);
		chk({15'h0000, err_irq}, 16'h0000);
		wr(ecs_pkg::REG_ERCFG, 16'h0003);
		repeat (2) @(posedge core_clk);
		chk({15'h0000, err_irq}, 16'h0001);
		$display("test faults done");
		test_done();
	end
endmodule : ecs_top_test
